// [shared/index_io_map.svh]
// Offsets, field positions, reset values and special values of the index I/O block.
// Included by the package; holds definitions only.
`ifndef INDEX_IO_MAP_SVH
`define INDEX_IO_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_ENC_MODE      16'h3007
`define IDX_START_INDEX   16'h3008
`define IDX_BUFFER_MODE   16'h3009
`define IDX_IO_CONFIG     16'h300A
`define IDX_REG_CONFIG    16'h300B
`define IDX_STATUS        16'h3020

// Reset values
`define RST_ENC_MODE      16'h0000
`define RST_START_INDEX   16'h0000
`define RST_BUFFER_MODE   16'h0001
`define RST_IO_CONFIG     16'h0000
`define RST_REG_CONFIG    16'h0000

// I/O configuration bit positions
`define CFG_HOLD_DONE     0
`define CFG_BOTH_EDGES    1
`define CFG_SPLIT_JOG     2
`define CFG_OVR_REALTIME  3
`define CFG_REG_BY_CONFIG 4
`define CFG_JOG_SOFTLIM   5
`define CFG_ORIGIN_OFF    6

// Start index value that selects the index-select inputs
`define START_FROM_PINS   16'h0040
// Registration configuration value meaning absolute target
`define REG_CFG_ABSOLUTE  16'h0001
// Buffer mode value for a single remembered start
`define BUF_SINGLE        16'h0001

// Status register field positions
`define ST_OUT_LSB        0
`define ST_COUNT_LSB      6
`define ST_RUNNING        8
`define ST_ORIGIN         9
`define ST_REG_REL        10
`define ST_SOFTLIM        11

`endif

// [shared/index_io_pkg.sv]
// Types shared by the index I/O configuration block and its leaves.
// Assumes index_io_map.svh is on the include path.
package index_io_pkg;
  `include "index_io_map.svh"

  // Digital inputs from the upper-level controller, asynchronous
  typedef struct packed {
    logic       startInput;
    logic [5:0] indexSelectInputs;
    logic       jogStartInput;
    logic       jogDirectionInput;
    logic       positiveJogInput;
    logic       negativeJogInput;
    logic       registrationTriggerInput;
  } pin_in_t;

  // Status from the motion core, same clock
  typedef struct packed {
    logic       running;
    logic       indexDone;
    logic [5:0] runningIndex;
    logic       startTaken;
    logic       regTypeRelative;
    logic       homingStart;
    logic       homingDone;
    logic       servoOn;
  } core_stat_t;

  // Jog command towards the motion core
  typedef struct packed {
    logic plus;
    logic minus;
  } jog_cmd_t;
endpackage : index_io_pkg

// [core/pin_sync.sv]
// Two-flop synchroniser for the controller's digital inputs.
// Assumes the inputs are asynchronous to clock.
`timescale 1ns/1ps
module pin_sync
  import index_io_pkg::*;
(
  input  wire logic    clock,
  input  wire logic    rst_n,
  input  wire pin_in_t pinsAsync,
  output pin_in_t      pinsSync
);
  typedef struct packed {
    pin_in_t meta;
    pin_in_t stable;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  // First stage feeds only the second
  always_comb begin
    state_d.meta   = pinsAsync;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign pinsSync = state_q.stable;
endmodule : pin_sync

// [core/start_queue.sv]
// Pending start requests, one or two deep, oldest first.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module start_queue
  import index_io_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       push,
  input  wire logic [5:0] pushIndex,
  input  wire logic       pop,
  input  wire logic       singleMode,
  output logic            headValid,
  output logic [5:0]      headIndex,
  output logic [1:0]      count
);
  typedef struct packed {
    logic [1:0][5:0] slots;
    logic [1:0]      count;
  } queue_state_t;

  queue_state_t state_q;
  queue_state_t state_d;

  // Pop first, then push into the freed place
  always_comb begin
    logic       popOk;
    logic [1:0] capacity;
    logic [1:0] left;
    popOk    = 1'b0;
    capacity = 2'h0;
    left     = 2'h0;
    state_d  = state_q;
    capacity = singleMode ? 2'h1 : 2'h2;
    popOk    = pop && (state_q.count != 2'h0);
    left     = state_q.count - {1'b0, popOk};
    if (popOk) begin
      state_d.slots[0] = state_q.slots[1];
    end
    // A full queue drops the new start
    if (push && (left < capacity)) begin
      state_d.slots[left[0]] = pushIndex;
      state_d.count          = left + 2'h1;
    end else begin
      state_d.count = left;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign headValid = (state_q.count != 2'h0);
  assign headIndex = state_q.slots[0];
  assign count     = state_q.count;
endmodule : start_queue

// [core/index_position_io_config.sv]
// Indexing position I/O configuration: parameter registers on APB,
// start edge capture and buffering, index output policy, jog input
// scheme, override timing, registration target mode and origin output.
// Assumes digital inputs are asynchronous and the motion core shares clock.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module index_position_io_config
  import index_io_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller pins and motion core
  input  wire pin_in_t     digitalInputs,
  input  wire core_stat_t  coreStatus,
  // Towards the motion core
  output logic             startPending,
  output logic [5:0]       startIndex,
  output jog_cmd_t         jogCommand,
  output logic             softLimitEnable,
  output logic             overrideRealTime,
  output logic             registrationPulse,
  output logic             registrationRelative,
  // Towards the pins
  output logic [5:0]       indexOutputLines,
  output logic             homingOriginOutput,
  output logic             encoderLineDrive
);

  // Register map, byte addresses
  // Encoder mode at 0xC01C
  // Start index at 0xC020
  // Buffer mode at 0xC024
  // I/O configuration at 0xC028
  // Registration config at 0xC02C
  // Status at 0xC080, read only
  // Only the low 16 bits are kept

  // Status word fields
  // Bits 5:0, index output lines
  // Bits 7:6, pending start count
  // Bit 8, motion core running
  // Bit 9, homing origin output
  // Bit 10, registration relative
  // Bit 11, soft limit enable

  // I/O configuration bits
  // Bit 0, hold last done index
  // Bit 1, both start edges
  // Bit 2, split jog inputs
  // Bit 3, real-time override
  // Bit 4, registration by config
  // Bit 5, soft limits in jog
  // Bit 6, origin off at servo off

  // Pin timing
  // Two edges through the flops
  // Edge found on the third
  // Outputs move on that same edge
  // Keep pin pulses over a cycle

  // Bus timing
  // Read data latched at setup
  // So status shows that cycle
  // Writes land at the access edge
  // No wait states are inserted

  // Limitations
  // Select pins must settle early
  // Else a mixed index is taken
  // Both split jogs high stop jog
  // So a stuck pin halts jog
  // Start values over 64 act as 64
  // A full buffer drops new starts
  // Nothing is queued during reset

  // Reset state
  // Buffer mode single, rest zero
  // Soft limits on, jog off
  // Origin output off
  // Index lines show zero

  // Jog coding, shared scheme
  // Start low means no jog
  // Direction low means plus
  // Direction high means minus

  // Registration target
  // Bit 4 clear: index type decides
  // Bit 4 set: configuration decides
  // Value 1 absolute, else relative
  typedef struct packed {
    logic [15:0] encMode;
    logic [15:0] startIdx;
    logic [15:0] bufMode;
    logic [15:0] ioCfg;
    logic [15:0] regCfg;
    logic [31:0] rdata;
    logic        slvErr;
    logic        prevStart;
    logic        prevReg;
    logic [5:0]  doneIdx;
    logic [5:0]  outLines;
    jog_cmd_t    jog;
    logic        softLim;
    logic        ovrRt;
    logic        regPulse;
    logic        regRel;
    logic        origin;
  } state_t;

  state_t     state_q;
  state_t     state_d;
  pin_in_t    pins;
  logic       startAccept;
  logic [5:0] selectedIndex;
  logic [1:0] pendingCount;

  // Byte address of a register index
  function automatic logic [15:0] addrOf(input logic [15:0] idx);
    addrOf = {idx[13:0], 2'b00};
  endfunction : addrOf

  // Rising edge, or either edge when asked for
  function automatic logic edgeSeen(input logic now, input logic prev,
                                    input logic both);
    edgeSeen = (now && !prev) || (both && !now && prev);
  endfunction : edgeSeen

  // Controller pins cross into the clock domain first
  pin_sync u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .pinsAsync(digitalInputs),
    .pinsSync (pins)
  );

  // Edge of the synchronised start input
  assign startAccept = edgeSeen(pins.startInput, state_q.prevStart,
                                state_q.ioCfg[`CFG_BOTH_EDGES]);

  // Select inputs only matter at value 64; above that treated alike
  always_comb begin
    if (state_q.startIdx >= `START_FROM_PINS) begin
      selectedIndex = pins.indexSelectInputs;
    end else begin
      selectedIndex = state_q.startIdx[5:0];
    end
  end

  // Pending starts wait here until the core takes them
  start_queue u_queue (
    .clock     (clock),
    .rst_n     (rst_n),
    .push      (startAccept),
    .pushIndex (selectedIndex),
    .pop       (coreStatus.startTaken),
    .singleMode(state_q.bufMode == `BUF_SINGLE),
    .headValid (startPending),
    .headIndex (startIndex),
    .count     (pendingCount)
  );

  // Next state of registers and pin-facing logic
  always_comb begin
    logic        setup;
    logic        hit;
    logic        jogOn;
    logic [15:0] wr;
    setup   = 1'b0;
    hit     = 1'b1;
    jogOn   = 1'b0;
    wr      = 16'h0000;
    state_d = state_q;

    // APB: decode in setup, answer in access, write at completion
    setup = psel && !penable;
    wr    = pwdata[15:0];
    if (setup) begin
      state_d.rdata = 32'h0000_0000;
      unique case (paddr)
        addrOf(`IDX_ENC_MODE):    state_d.rdata[15:0] = state_q.encMode;
        addrOf(`IDX_START_INDEX): state_d.rdata[15:0] = state_q.startIdx;
        addrOf(`IDX_BUFFER_MODE): state_d.rdata[15:0] = state_q.bufMode;
        addrOf(`IDX_IO_CONFIG):   state_d.rdata[15:0] = state_q.ioCfg;
        addrOf(`IDX_REG_CONFIG):  state_d.rdata[15:0] = state_q.regCfg;
        addrOf(`IDX_STATUS): begin
          state_d.rdata[`ST_OUT_LSB +: 6]   = state_q.outLines;
          state_d.rdata[`ST_COUNT_LSB +: 2] = pendingCount;
          state_d.rdata[`ST_RUNNING]        = coreStatus.running;
          state_d.rdata[`ST_ORIGIN]         = state_q.origin;
          state_d.rdata[`ST_REG_REL]        = state_q.regRel;
          state_d.rdata[`ST_SOFTLIM]        = state_q.softLim;
        end
        default: hit = 1'b0;
      endcase
      // Status is read only, so a write to it is an error too
      state_d.slvErr = !hit ||
                       (pwrite && paddr == addrOf(`IDX_STATUS));
    end
    if (psel && penable && pwrite && !state_q.slvErr) begin
      unique case (paddr)
        // Held for software only; line drive is the one method
        addrOf(`IDX_ENC_MODE):    state_d.encMode  = wr;
        addrOf(`IDX_START_INDEX): state_d.startIdx = wr;
        addrOf(`IDX_BUFFER_MODE): state_d.bufMode  = wr;
        addrOf(`IDX_IO_CONFIG):   state_d.ioCfg    = wr;
        addrOf(`IDX_REG_CONFIG):  state_d.regCfg   = wr;
        default: ;
      endcase
    end

    // Edge history of the synchronised inputs
    state_d.prevStart = pins.startInput;
    state_d.prevReg   = pins.registrationTriggerInput;

    // Completed index captured at the end of each operation
    if (coreStatus.indexDone) begin
      state_d.doneIdx = coreStatus.runningIndex;
    end

    // Index output lines: live or hold-last while running
    if (coreStatus.indexDone) begin
      state_d.outLines = coreStatus.runningIndex;
    end else if (coreStatus.running &&
                 !state_q.ioCfg[`CFG_HOLD_DONE]) begin
      state_d.outLines = coreStatus.runningIndex;
    end else begin
      state_d.outLines = state_q.doneIdx;
    end

    // Jog scheme; opposing split inputs cancel rather than pick one
    if (state_q.ioCfg[`CFG_SPLIT_JOG]) begin
      state_d.jog.plus  = pins.positiveJogInput &&
                          !pins.negativeJogInput;
      state_d.jog.minus = pins.negativeJogInput &&
                          !pins.positiveJogInput;
    end else begin
      state_d.jog.plus  = pins.jogStartInput &&
                          !pins.jogDirectionInput;
      state_d.jog.minus = pins.jogStartInput &&
                          pins.jogDirectionInput;
    end

    // Soft limits always on outside jog
    jogOn           = state_d.jog.plus || state_d.jog.minus;
    state_d.softLim = !jogOn ||
                      state_q.ioCfg[`CFG_JOG_SOFTLIM];

    // Override timing follows the configuration directly
    state_d.ovrRt = state_q.ioCfg[`CFG_OVR_REALTIME];

    // Registration trigger: one pulse with its target mode
    state_d.regPulse = pins.registrationTriggerInput &&
                       !state_q.prevReg;
    if (state_d.regPulse) begin
      if (state_q.ioCfg[`CFG_REG_BY_CONFIG]) begin
        // Reserved values fall back to relative
        state_d.regRel = (state_q.regCfg != `REG_CFG_ABSOLUTE);
      end else begin
        state_d.regRel = coreStatus.regTypeRelative;
      end
    end

    // Origin output: homing completion wins over any clear
    if (coreStatus.homingDone) begin
      state_d.origin = 1'b1;
    end else if (coreStatus.homingStart) begin
      state_d.origin = 1'b0;
    end else if (!coreStatus.servoOn &&
                 state_q.ioCfg[`CFG_ORIGIN_OFF]) begin
      state_d.origin = 1'b0;
    end
  end

  // Single register stage for all block state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Each field named so none is left to chance
      state_q.encMode   <= `RST_ENC_MODE;
      state_q.startIdx  <= `RST_START_INDEX;
      state_q.bufMode   <= `RST_BUFFER_MODE;
      state_q.ioCfg     <= `RST_IO_CONFIG;
      state_q.regCfg    <= `RST_REG_CONFIG;
      state_q.rdata     <= 32'h0000_0000;
      state_q.slvErr    <= 1'b0;
      state_q.prevStart <= 1'b0;
      state_q.prevReg   <= 1'b0;
      state_q.doneIdx   <= 6'h00;
      state_q.outLines  <= 6'h00;
      state_q.jog       <= '0;
      state_q.softLim   <= 1'b1;
      state_q.ovrRt     <= 1'b0;
      state_q.regPulse  <= 1'b0;
      state_q.regRel    <= 1'b0;
      state_q.origin    <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Zero-wait slave: data was prepared in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = state_q.rdata;
  assign pslverr = psel && penable && state_q.slvErr;

  // Outputs straight from flops
  assign indexOutputLines     = state_q.outLines;
  assign jogCommand           = state_q.jog;
  assign softLimitEnable      = state_q.softLim;
  assign overrideRealTime     = state_q.ovrRt;
  assign registrationPulse    = state_q.regPulse;
  assign registrationRelative = state_q.regRel;
  assign homingOriginOutput   = state_q.origin;
  // No other encoder method exists in this drive
  assign encoderLineDrive     = 1'b1;
endmodule : index_position_io_config

// [sim/index_position_io_config_props.sv]
// Port checker for index_position_io_config.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module index_position_io_config_props
  import index_io_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire pin_in_t    digitalInputs,
  input wire core_stat_t coreStatus,
  input wire logic       startPending,
  input wire jog_cmd_t   jogCommand,
  input wire logic       softLimitEnable,
  input wire logic       registrationPulse,
  input wire logic [5:0] indexOutputLines,
  input wire logic       homingOriginOutput,
  input wire logic       encoderLineDrive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Pin aliases; three edges of synchroniser and detect delay
  wire regtPin  = digitalInputs.registrationTriggerInput;
  wire startPin = digitalInputs.startInput;
  wire jogOn    = jogCommand.plus || jogCommand.minus;

  AST_LINE_DRIVE: assert property (encoderLineDrive) else $error("line drive off");
  AST_OUT_DONE: assert property (coreStatus.indexDone |=>
    indexOutputLines == $past(coreStatus.runningIndex)) else $error("done index not shown");
  AST_REG_PULSE: assert property (registrationPulse ==
    ($past(regtPin, 3) && !$past(regtPin, 4))) else $error("trigger pulse misplaced");
  AST_START_EDGE: assert property ($rose(startPending) |->
    $past(startPin, 3) != $past(startPin, 4)) else $error("start without edge");
  AST_PEND_HOLD: assert property (startPending && !coreStatus.startTaken |=>
    startPending) else $error("pending start lost");
  AST_ORIGIN_SET: assert property (coreStatus.homingDone |=>
    homingOriginOutput) else $error("origin not set");
  AST_ORIGIN_CLR: assert property (coreStatus.homingStart && !coreStatus.homingDone |=>
    !homingOriginOutput) else $error("origin not cleared");
  AST_ORIGIN_KEEP: assert property (coreStatus.servoOn && !coreStatus.homingStart &&
    !coreStatus.homingDone |=> $stable(homingOriginOutput)) else $error("origin changed");
  AST_JOG_EXCL: assert property (!(jogCommand.plus && jogCommand.minus)) else $error("both jogs");
  AST_SOFTLIM: assert property (!jogOn |-> softLimitEnable) else $error("limits off idle");

  // Main scenarios reached
  cover property (registrationPulse);
  cover property (startPending && coreStatus.startTaken);
  cover property (jogCommand.minus && !softLimitEnable);
endmodule : index_position_io_config_props

bind index_position_io_config index_position_io_config_props i_props (.clock, .rst_n,
  .digitalInputs, .coreStatus, .startPending, .jogCommand, .softLimitEnable, .registrationPulse,
  .indexOutputLines, .homingOriginOutput, .encoderLineDrive);

// [sim/controller_model.sv]
// Upper-level controller model driving start, select, jog and trigger pins.
// Assumes one start request at a time; req is a one-cycle pulse.
`timescale 1ns/1ps
module controller_model
  import index_io_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       req,
  input  wire logic [5:0] reqSel,
  input  wire logic [4:0] levels,
  output pin_in_t         pins,
  output logic            busy
);
  logic [3:0] step;
  initial begin
    step = 4'h0;
    pins = '0;
  end
  assign busy = req || step != 4'h0;
  // Select churns between frames, so a late sample shows up; held across the pulse
  always @(posedge clock) begin
    if (req) begin
      step <= 4'h1;
      pins.indexSelectInputs <= reqSel;
    end else if (step != 4'h0) begin
      step <= step + 4'h1;
    end else begin
      pins.indexSelectInputs <= ~pins.indexSelectInputs;
    end
    pins.startInput <= step >= 4'h3 && step < 4'h7;
    {pins.jogStartInput, pins.jogDirectionInput, pins.positiveJogInput,
     pins.negativeJogInput, pins.registrationTriggerInput} <= levels;
  end
endmodule : controller_model

// [sim/index_position_io_config_test.sv]
// Self-checking bench for index_position_io_config with a queue model.
// Assumes the controller model drives the pins and the bench plays the core.
`timescale 1ns/1ps
`include "index_io_map.svh"
module index_position_io_config_test
  import index_io_pkg::*;
;
  logic        clock, rst_n, psel, penable, pwrite, req, err, busy, ep, em, b4;
  logic        pready, pslverr, startPending, softLimitEnable, overrideRealTime;
  logic        registrationPulse, registrationRelative, homingOriginOutput, encoderLineDrive;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, d;
  logic [5:0]  startIndex, indexOutputLines, reqSel, r;
  logic [4:0]  levels;
  pin_in_t     pins;
  core_stat_t  cs;
  jog_cmd_t    jogCommand;
  int          failures, checkCount, cyc, cap, lastDone;
  int          q[$];
  logic [15:0] idx [5] = '{`IDX_ENC_MODE, `IDX_START_INDEX, `IDX_BUFFER_MODE, `IDX_IO_CONFIG,
                           `IDX_REG_CONFIG};
  logic [15:0] rv [5] = '{`RST_ENC_MODE, `RST_START_INDEX, `RST_BUFFER_MODE, `RST_IO_CONFIG,
                          `RST_REG_CONFIG};

  index_position_io_config i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .digitalInputs(pins), .coreStatus(cs), .startPending, .startIndex,
    .jogCommand, .softLimitEnable, .overrideRealTime, .registrationPulse, .registrationRelative,
    .indexOutputLines, .homingOriginOutput, .encoderLineDrive);
  controller_model i_ctl (.clock, .req, .reqSel, .levels, .pins, .busy);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checkCount++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer; result taken at the edge that samples pready
  task automatic apb(logic w, logic [15:0] i, logic [31:0] dv);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= i * 16'h0004;
    pwdata <= dv;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Model keeps the first starts up to capacity, drops the rest
  task automatic start(int n, logic [5:0] s, int pushes);
    @(posedge clock);
    req <= 1'b1;
    reqSel <= s;
    @(posedge clock);
    req <= 1'b0;
    repeat (2) @(posedge clock);
    while (busy) @(posedge clock);
    repeat (pushes) if (q.size() < cap) q.push_back(n == 64 ? s : n);
  endtask : start
  task automatic qchk();
    apb(1'b0, `IDX_STATUS, 32'h0);
    chk("count", rd[7:6], q.size());
    chk("pending", startPending, q.size() != 0);
    if (q.size() != 0) chk("index", startIndex, q[0]);
  endtask : qchk
  task automatic pop();
    @(posedge clock);
    cs.startTaken <= 1'b1;
    @(posedge clock);
    cs.startTaken <= 1'b0;
    void'(q.pop_front());
    repeat (2) @(posedge clock);
    qchk();
  endtask : pop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  initial begin
    {psel, penable, pwrite, req, paddr, pwdata, reqSel, levels, cs} = '0;
    seed = 32'h0001189A;
    rst_n = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values, then random write and read back
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, idx[k], 32'h0);
      chk("reset", rd, rv[k]);
      d = rnd();
      apb(1'b1, idx[k], d);
      apb(1'b0, idx[k], 32'h0);
      chk("readback", rd, d & 32'h0000FFFF);
    end
    apb(1'b0, 16'h3030, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, `IDX_STATUS, 32'h1);
    chk("ro write", err, 1'b1);
    chk("line drive", encoderLineDrive, 1'b1);
    // Single buffer, fixed index; second start dropped
    apb(1'b1, `IDX_IO_CONFIG, 32'h0);
    apb(1'b1, `IDX_BUFFER_MODE, 32'h1);
    apb(1'b1, `IDX_START_INDEX, 32'h5);
    cap = 1;
    start(5, 6'(rnd()), 1);
    start(5, 6'(rnd()), 1);
    qchk();
    pop();
    // Double buffer, index from select pins, third start dropped
    apb(1'b1, `IDX_BUFFER_MODE, 32'h0);
    apb(1'b1, `IDX_START_INDEX, 32'h40);
    cap = 2;
    // One pulse gives one start: the falling edge is ignored
    start(64, 6'(rnd()), 1);
    qchk();
    repeat (2) start(64, 6'(rnd()), 1);
    qchk();
    pop();
    pop();
    // Both edges: one pulse gives two starts
    apb(1'b1, `IDX_IO_CONFIG, 32'h2);
    start(64, 6'(rnd()), 2);
    qchk();
    pop();
    pop();
    // Index output policy and override timing
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, `IDX_IO_CONFIG, b * 9);
      // Config lands at the access edge, the copy one edge later
      repeat (2) @(posedge clock);
      chk("override", overrideRealTime, b);
      r = 6'(rnd());
      // Unlike the held index, so live and hold policies differ
      if (r == lastDone[5:0]) r = ~r;
      cs.running <= 1'b1;
      cs.runningIndex <= r;
      repeat (4) @(posedge clock);
      chk("run out", indexOutputLines, b ? lastDone : r);
      cs.indexDone <= 1'b1;
      @(posedge clock);
      {cs.indexDone, cs.running} <= 2'b00;
      lastDone = r;
      repeat (2) @(posedge clock);
      chk("done out", indexOutputLines, r);
    end
    // Jog schemes and soft limits over all pin combinations
    for (int m = 0; m < 64; m++) begin
      if (m % 16 == 0) apb(1'b1, `IDX_IO_CONFIG, (m & 16) >> 2 | (m & 32) >> 0);
      levels <= {m[3:0], 1'b0};
      repeat (5) @(posedge clock);
      ep = m[4] ? m[1] & !m[0] : m[3] & !m[2];
      em = m[4] ? m[0] & !m[1] : m[3] & m[2];
      chk("jog", {jogCommand.plus, jogCommand.minus}, {ep, em});
      chk("soft limit", softLimitEnable, !(ep | em) | m[5]);
    end
    // Registration target mode: config 0, reserved 2 and 1
    for (int k = 0; k < 8; k++) begin
      b4 = k[2];
      d = k[1] ? 1 : 2 * k[0];
      cs.regTypeRelative <= k[0];
      apb(1'b1, `IDX_REG_CONFIG, d);
      apb(1'b1, `IDX_IO_CONFIG, b4 << 4);
      levels <= 5'h01;
      for (int w = 0; w < 10 && registrationPulse !== 1'b1; w++) @(posedge clock);
      chk("reg pulse", registrationPulse, 1'b1);
      chk("reg rel", registrationRelative, b4 ? d != 1 : k[0]);
      levels <= 5'h00;
      repeat (4) @(posedge clock);
    end
    // Origin output after homing and servo off
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, `IDX_IO_CONFIG, b << 6);
      {cs.servoOn, cs.homingStart} <= 2'b11;
      @(posedge clock);
      {cs.homingStart, cs.homingDone} <= 2'b01;
      @(posedge clock);
      cs.homingDone <= 1'b0;
      repeat (2) @(posedge clock);
      chk("origin", homingOriginOutput, 1'b1);
      cs.servoOn <= 1'b0;
      repeat (3) @(posedge clock);
      chk("origin off", homingOriginOutput, !b);
    end
    end_sim();
  end
endmodule : index_position_io_config_test
